/* eqt_map.vh */
`ifndef EQT_MAP_VH
`define EQT_MAP_VH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define EQT_IDX_W             7
`define EQT_IDX_CTRL          7'h00
`define EQT_IDX_STATUS        7'h01
`define EQT_IDX_EXT_POINTER   7'h15
`define EQT_IDX_SIG_FIRST     7'h39
`define EQT_IDX_SIG_SECOND    7'h3A
`define EQT_IDX_SIG_THIRD     7'h3B
`define EQT_IDX_VER_MAJOR     7'h3C
`define EQT_IDX_VER_MINOR     7'h3D
`define EQT_IDX_FEAT_BYTE0    7'h3E
`define EQT_IDX_FEAT_BYTE1    7'h3F
`define EQT_IDX_FEAT_BYTE2    7'h40
`define EQT_IDX_FEAT_BYTE3    7'h41
`define EQT_IDX_AFTER_SUSP    7'h42
`define EQT_IDX_BLK_STAT_LO   7'h43
`define EQT_IDX_BLK_STAT_HI   7'h44
`define EQT_IDX_VDD_OPT       7'h45
`define EQT_IDX_VPP_OPT       7'h46

// ****************************************************************
// table contents
// ****************************************************************
`define EQT_VAL_EXT_POINTER   8'h39
`define EQT_VAL_SIG_FIRST     8'h50
`define EQT_VAL_SIG_SECOND    8'h52
`define EQT_VAL_SIG_THIRD     8'h49
`define EQT_VAL_VER_MAJOR     8'h31
`define EQT_VAL_VER_MINOR     8'h33
`define EQT_VAL_FEAT_BYTE0    8'hE6
`define EQT_VAL_FEAT_BYTE1    8'h03
`define EQT_VAL_FEAT_BYTE2    8'h00
`define EQT_VAL_FEAT_BYTE3    8'h00
`define EQT_VAL_AFTER_SUSP    8'h01
`define EQT_VAL_BLK_STAT_LO   8'h03
`define EQT_VAL_BLK_STAT_HI   8'h00
`define EQT_VAL_VDD_OPT       8'h18
`define EQT_VAL_VPP_OPT       8'hC0

// ****************************************************************
// control and status fields
// ****************************************************************
`define EQT_CTRL_QUERY_EN_BIT 0
`define EQT_CTRL_RESET        1'b1
`define EQT_HIGH_ADDR_MSB     31
`define EQT_HIGH_ADDR_LSB     9

`endif

/* eqt_rom.v */
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
`include "eqt_map.vh"

module eqt_rom (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata
);

  // ****************************************************************
  // address phase decode
  // ****************************************************************
  wire                   access_go;
  wire                   addr_high_zero;
  wire [`EQT_IDX_W-1:0]  idx;

  assign access_go      = hsel & hready & htrans[1];
  assign addr_high_zero = (haddr[`EQT_HIGH_ADDR_MSB:`EQT_HIGH_ADDR_LSB] == 23'h00_0000);
  assign idx            = haddr[`EQT_HIGH_ADDR_LSB-1:2];

  // zero wait states: every answer lands in the first data-phase cycle
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  reg                   ctrl_query_en_q;
  reg [15:0]            hit_count_q;
  reg [31:0]            hrdata_q;
  reg                   wr_pend_q;
  reg [`EQT_IDX_W-1:0]  wr_idx_q;

  // ****************************************************************
  // table lookup
  // ****************************************************************
  reg [7:0] table_byte;
  reg       table_hit;

  always @* begin
    table_hit  = 1'b1;
    table_byte = 8'h00;
    case (idx)
      `EQT_IDX_EXT_POINTER: table_byte = `EQT_VAL_EXT_POINTER;
      `EQT_IDX_SIG_FIRST:   table_byte = `EQT_VAL_SIG_FIRST;
      `EQT_IDX_SIG_SECOND:  table_byte = `EQT_VAL_SIG_SECOND;
      `EQT_IDX_SIG_THIRD:   table_byte = `EQT_VAL_SIG_THIRD;
      `EQT_IDX_VER_MAJOR:   table_byte = `EQT_VAL_VER_MAJOR;
      `EQT_IDX_VER_MINOR:   table_byte = `EQT_VAL_VER_MINOR;
      // feature bits 1,2,5,6,7 in byte0; 8,9 in byte1
      `EQT_IDX_FEAT_BYTE0:  table_byte = `EQT_VAL_FEAT_BYTE0;
      `EQT_IDX_FEAT_BYTE1:  table_byte = `EQT_VAL_FEAT_BYTE1;
      `EQT_IDX_FEAT_BYTE2:  table_byte = `EQT_VAL_FEAT_BYTE2;
      `EQT_IDX_FEAT_BYTE3:  table_byte = `EQT_VAL_FEAT_BYTE3;
      `EQT_IDX_AFTER_SUSP:  table_byte = `EQT_VAL_AFTER_SUSP;
      `EQT_IDX_BLK_STAT_LO: table_byte = `EQT_VAL_BLK_STAT_LO;
      `EQT_IDX_BLK_STAT_HI: table_byte = `EQT_VAL_BLK_STAT_HI;
      `EQT_IDX_VDD_OPT:     table_byte = `EQT_VAL_VDD_OPT;
      `EQT_IDX_VPP_OPT:     table_byte = `EQT_VAL_VPP_OPT;
      default:              table_hit  = 1'b0;
    endcase
  end

  // ****************************************************************
  // read data mux
  // ****************************************************************
  reg [31:0] rdata_d;

  always @* begin
    rdata_d = 32'h0000_0000;
    if (addr_high_zero) begin
      if (idx == `EQT_IDX_CTRL) begin
        rdata_d[`EQT_CTRL_QUERY_EN_BIT] = ctrl_query_en_q;
      end else if (idx == `EQT_IDX_STATUS) begin
        rdata_d[15:0] = hit_count_q;
      end else if (table_hit && ctrl_query_en_q) begin
        rdata_d = {24'h00_0000, table_byte};
      end
    end
  end

  // ****************************************************************
  // bus registers
  // ****************************************************************
  // write data arrives a cycle after the address, so the index is held
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_query_en_q <= `EQT_CTRL_RESET;
      hit_count_q     <= 16'h0000;
      hrdata_q        <= 32'h0000_0000;
      wr_pend_q       <= 1'b0;
      wr_idx_q        <= 7'h00;
    end else begin
      if (hready) begin
        wr_pend_q <= access_go & hwrite & addr_high_zero;
        wr_idx_q  <= idx;
      end
      if (access_go && !hwrite) begin
        hrdata_q <= rdata_d;
        // table reads only count while query mode is on
        if (addr_high_zero && table_hit && ctrl_query_en_q) begin
          hit_count_q <= hit_count_q + 16'h0001;
        end
      end
      if (wr_pend_q && (wr_idx_q == `EQT_IDX_CTRL)) begin
        ctrl_query_en_q <= hwdata[`EQT_CTRL_QUERY_EN_BIT];
      end
    end
  end

  assign hrdata = hrdata_q;

endmodule // eqt_rom

/* eqt_host.sv */
`timescale 1ns/10ps
module eqt_host (
  input  wire         hclk,
  input  wire         hready,
  input  wire  [31:0] hrdata,
  output logic        hsel = 1'b0,
  output logic [31:0] haddr = 32'h0000_0000,
  output logic [1:0]  htrans = 2'b00,
  output logic        hwrite = 1'b0,
  output logic [31:0] hwdata = 32'h0000_0000
);
  // single word transfer; no wait count assumed, the bench watchdog bounds a hang
  task automatic xfer(input logic w, input logic [31:0] a, wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd;
  endtask
endmodule // eqt_host

/* eqt_rom_chk.sv */
`timescale 1ns/10ps
module eqt_rom_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata
);
  logic wr_ctrl_q;
  logic en_q;
  // mirror of query enable, since a hidden table legally reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ctrl_q <= 1'b0;
      en_q      <= 1'b1;
    end else begin
      wr_ctrl_q <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0000_0000;
      if (wr_ctrl_q) en_q <= hwdata[0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_at(logic [6:0] a);
    hsel && hready && htrans[1] && !hwrite && en_q && haddr == {23'h00_0000, a, 2'b00};
  endsequence
  property tbl(logic [6:0] a, logic [31:0] v);
    rd_at(a) |=> hrdata == v;
  endproperty
  chk_ptr_word: assert property (tbl(7'h15, 32'h0000_0039)) else $error("ptr");
  chk_sig_char: assert property (tbl(7'h3a, 32'h0000_0052)) else $error("sig");
  chk_ver_major: assert property (tbl(7'h3c, 32'h0000_0031)) else $error("major");
  chk_ver_minor: assert property (tbl(7'h3d, 32'h0000_0033)) else $error("minor");
  chk_feat_low: assert property (tbl(7'h3e, 32'h0000_00e6)) else $error("feat");
  chk_feat_top: assert property (tbl(7'h41, 32'h0000_0000)) else $error("feat3");
  chk_after_susp: assert property (tbl(7'h42, 32'h0000_0001)) else $error("susp");
  chk_blk_status: assert property (tbl(7'h43, 32'h0000_0003)) else $error("blk");
  chk_vdd_opt: assert property (tbl(7'h45, 32'h0000_0018)) else $error("vdd");
  chk_vpp_opt: assert property (tbl(7'h46, 32'h0000_00c0)) else $error("vpp");
  chk_sig_first: assert property (tbl(7'h39, 32'h0000_0050)) else $error("sig1");
endmodule // eqt_rom_chk
bind eqt_rom eqt_rom_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata);

/* tb_extended_query_table_rom.sv */
`timescale 1ns/10ps
module tb_extended_query_table_rom;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] rd;
  wire         hsel, hwrite, hready, hresp;
  wire  [1:0]  htrans;
  wire  [2:0]  hsize = 3'b010;
  wire  [31:0] haddr, hwdata, hrdata;
  int          err_total = 0;
  int          num_checks = 0;
  localparam logic [7:0] val_tbl [15] = '{8'h39, 8'h50, 8'h52, 8'h49, 8'h31, 8'h33, 8'he6,
    8'h03, 8'h00, 8'h00, 8'h01, 8'h03, 8'h00, 8'h18, 8'hc0};
  eqt_rom DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout(hready), .hresp, .hrdata);
  eqt_host HOST (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hwdata);
  initial forever #5 hclk = ~hclk;
  task automatic check(input logic [31:0] a, seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED addr %h expected %h seen %h", a, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic rc(input logic [31:0] a, exp);
    HOST.xfer(1'b0, a, 32'h0000_0000, rd);
    check(a, rd, exp);
  endtask
  task automatic t_table;  // each entry in turn, an idle cycle between reads, then the read tally
    logic [31:0] a;
    for (int i = 0; i < 15; i++) begin
      a = (i == 0) ? 32'h0000_0054 : 32'h0000_00e0 + 32'(i * 4);
      rc(a, 32'(val_tbl[i]));
    end
    rc(32'h0000_0004, 32'h0000_000f);
    check(32'h0000_0000, {31'h0000_0000, hresp}, 32'h0000_0000);
  endtask
  task automatic t_enable;  // enable off hides the table, back on restores it
    rc(32'h0000_0000, 32'h0000_0001);
    HOST.xfer(1'b1, 32'h0000_0000, 32'h0000_0000, rd);
    rc(32'h0000_00e4, 32'h0000_0000);
    HOST.xfer(1'b1, 32'h0000_0000, 32'h0000_0001, rd);
    rc(32'h0000_0118, 32'h0000_00c0);
  endtask
  task automatic t_readonly;  // table writes and stray addresses change nothing
    HOST.xfer(1'b1, 32'h0000_00e4, 32'h0000_00aa, rd);
    rc(32'h0000_0200, 32'h0000_0000);
    rc(32'h0000_00e4, 32'h0000_0050);
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_table();
    t_enable();
    t_readonly();
    results();
  end
  initial begin
    #20000;
    err_total++;
    results();
  end
endmodule // tb_extended_query_table_rom
